// >>> logic/otfr_consts.svh
// Constants for the overtemperature fault response block.
// Assumes a single 125 MHz clock; times are held in milliseconds.
`ifndef OTFR_CONSTS_SVH
`define OTFR_CONSTS_SVH

// Register map and field layout
`define OTFR_ADDR_OT_ACTION 8'h50
`define OTFR_OT_ACTION_RST  8'h00
`define OTFR_RESP_HI        7
`define OTFR_RESP_LO        6
`define OTFR_RETRY_HI       5
`define OTFR_RETRY_LO       3
`define OTFR_DLY_HI         2
`define OTFR_DLY_LO         0

// Response codes and retry encoding
`define OTFR_RESP_IGNORE    2'h0
`define OTFR_RESP_HOLD      2'h1
`define OTFR_RESP_SHUT      2'h2
`define OTFR_RESP_WAITCLR   2'h3
`define OTFR_RETRY_INF      3'h7

// Timing
`define OTFR_CLK_PERIOD_NS  8
`define OTFR_MS_NS          1000000
`define OTFR_CYC_PER_MS     (`OTFR_MS_NS / `OTFR_CLK_PERIOD_NS)

// Hold delays per delay code, ms
`define OTFR_T1_MS_0        12'd10
`define OTFR_T1_MS_1        12'd20
`define OTFR_T1_MS_2        12'd40
`define OTFR_T1_MS_3        12'd80
`define OTFR_T1_MS_4        12'd160
`define OTFR_T1_MS_5        12'd320
`define OTFR_T1_MS_6        12'd640
`define OTFR_T1_MS_7        12'd1280

// Restart intervals per delay code, ms
`define OTFR_T2_MS_0        12'd252
`define OTFR_T2_MS_1        12'd558
`define OTFR_T2_MS_2        12'd924
`define OTFR_T2_MS_3        12'd1260
`define OTFR_T2_MS_4        12'd1596
`define OTFR_T2_MS_5        12'd1932
`define OTFR_T2_MS_6        12'd2268
`define OTFR_T2_MS_7        12'd2604

`endif

// >>> logic/otfr_pkg.sv
// Types for the overtemperature fault response block.
// Assumes nothing of its surroundings.
`default_nettype none

package otfr_pkg;

  typedef enum logic [2:0] {
    OTFR_RUN,
    OTFR_HOLD,
    OTFR_OFF_WAIT,
    OTFR_TRY,
    OTFR_WAIT_CLEAR,
    OTFR_LATCHED
  } otfr_state_t;

  typedef logic [11:0] otfr_ms_t;

endpackage

`default_nettype wire

// >>> logic/otfr_ms_timer.sv
// Millisecond down-timer: a start pulse loads a count of milliseconds,
// and a one-cycle expiry pulse follows once they have elapsed.
// Assumes start comes from logic on mclk.
`default_nettype none

module otfr_ms_timer #(
  parameter int CYC_PER_MS = 125000
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Control
  input  wire logic              start,
  input  wire otfr_pkg::otfr_ms_t load_ms,
  // Status
  output logic                   expired
);
  import otfr_pkg::*;

  logic [31:0] pre_q, pre_d;
  otfr_ms_t    ms_q, ms_d;
  logic        run_q, run_d;
  logic        exp_q, exp_d;

  always_comb begin
    pre_d = pre_q;
    ms_d  = ms_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (start) begin
      pre_d = '0;
      ms_d  = load_ms;
      run_d = (load_ms != '0);
      exp_d = (load_ms == '0);
    end else if (run_q) begin
      if (pre_q == 32'(CYC_PER_MS - 1)) begin
        pre_d = '0;
        ms_d  = ms_q - 12'h001;
        if (ms_q == 12'h001) begin
          run_d = 1'b0;
          exp_d = 1'b1;
        end
      end else begin
        pre_d = pre_q + 32'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      ms_q  <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      pre_q <= pre_d;
      ms_q  <= ms_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule // otfr_ms_timer

`default_nettype wire

// >>> logic/otfr_fault_resp.sv
// Overtemperature fault response: holds the action register and drives
// the output enable through ignore, ride-through, shutdown-retry and
// wait-for-clear reactions.
// Assumes ot_fault comes from sensing logic on mclk and that register
// writes are single-cycle strobes on mclk.
//
// Overview of operation
// (RULE_01) Response 00: overtemperature fault is ignored
// (RULE_02) Response 01: run on for hold delay
// (RULE_03) Response 01: fault persists, start retry attempts
// (RULE_04) Response 10: shut down now, retry at interval
// (RULE_05) Response 11: output off while fault present
// (RULE_06) Response 11: auto re-enable once fault clears
// (RULE_07) Retry field counts attempts; 111 is endless
// (RULE_08) Retries exhausted: stay off until reset
// (RULE_09) Restart interval spaces consecutive attempts
// (RULE_10) Fault gone during hold: carry on normally
`default_nettype none
`include "otfr_consts.svh"

module otfr_fault_resp #(
  parameter int CYC_PER_MS = `OTFR_CYC_PER_MS
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Register port
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Fault input
  input  wire logic       ot_fault,
  // Power stage control and status
  output logic            out_enable,
  output logic            restart_stb,
  output logic            fault_latched
);
  import otfr_pkg::*;

  logic [7:0]  act_q, act_d;
  logic [7:0]  rdata_q, rdata_d;
  otfr_state_t st_q, st_d;
  logic [2:0]  used_q, used_d;
  logic        oen_q, oen_d;
  logic        rst_stb_q, rst_stb_d;
  logic        tmr_start;
  otfr_ms_t    tmr_ms;
  logic        tmr_exp;

  logic [1:0]  resp;
  logic [2:0]  retry_lim;
  logic [2:0]  dly_code;
  otfr_ms_t    hold_ms;
  otfr_ms_t    gap_ms;

  assign resp      = act_q[`OTFR_RESP_HI:`OTFR_RESP_LO];
  assign retry_lim = act_q[`OTFR_RETRY_HI:`OTFR_RETRY_LO];
  assign dly_code  = act_q[`OTFR_DLY_HI:`OTFR_DLY_LO];

  // Delay code lookup for both timing columns
  always_comb begin
    unique case (dly_code)
      3'h0: begin hold_ms = `OTFR_T1_MS_0; gap_ms = `OTFR_T2_MS_0; end
      3'h1: begin hold_ms = `OTFR_T1_MS_1; gap_ms = `OTFR_T2_MS_1; end
      3'h2: begin hold_ms = `OTFR_T1_MS_2; gap_ms = `OTFR_T2_MS_2; end
      3'h3: begin hold_ms = `OTFR_T1_MS_3; gap_ms = `OTFR_T2_MS_3; end
      3'h4: begin hold_ms = `OTFR_T1_MS_4; gap_ms = `OTFR_T2_MS_4; end
      3'h5: begin hold_ms = `OTFR_T1_MS_5; gap_ms = `OTFR_T2_MS_5; end
      3'h6: begin hold_ms = `OTFR_T1_MS_6; gap_ms = `OTFR_T2_MS_6; end
      3'h7: begin hold_ms = `OTFR_T1_MS_7; gap_ms = `OTFR_T2_MS_7; end
    endcase
  end

  // Register port
  always_comb begin
    act_d = act_q;
    if (reg_wr_en && reg_addr == `OTFR_ADDR_OT_ACTION) begin
      act_d = reg_wdata;
    end
    rdata_d = (reg_addr == `OTFR_ADDR_OT_ACTION) ? act_q : 8'h00;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      act_q   <= `OTFR_OT_ACTION_RST;
      rdata_q <= 8'h00;
    end else begin
      act_q   <= act_d;
      rdata_q <= rdata_d;
    end
  end

  // Fault reaction sequencer
  always_comb begin
    st_d      = st_q;
    used_d    = used_q;
    oen_d     = oen_q;
    rst_stb_d = 1'b0;
    tmr_start = 1'b0;
    tmr_ms    = gap_ms;
    unique case (st_q)
      OTFR_RUN: begin
        oen_d  = 1'b1;
        used_d = 3'h0;
        if (ot_fault) begin
          unique case (resp)
            `OTFR_RESP_IGNORE: st_d = OTFR_RUN; // see RULE_01
            `OTFR_RESP_HOLD: begin
              st_d      = OTFR_HOLD; // see RULE_02
              tmr_start = 1'b1;
              tmr_ms    = hold_ms;
            end
            `OTFR_RESP_SHUT: begin
              oen_d = 1'b0; // see RULE_04
              if (retry_lim == 3'h0) begin
                st_d = OTFR_LATCHED; // see RULE_08
              end else begin
                st_d      = OTFR_OFF_WAIT;
                tmr_start = 1'b1;
              end
            end
            `OTFR_RESP_WAITCLR: begin
              oen_d = 1'b0; // see RULE_05
              st_d  = OTFR_WAIT_CLEAR;
            end
          endcase
        end
      end
      OTFR_HOLD: begin
        if (!ot_fault) begin
          st_d = OTFR_RUN; // see RULE_10
        end else if (tmr_exp) begin
          oen_d = 1'b0; // see RULE_03
          if (retry_lim == 3'h0) begin
            st_d = OTFR_LATCHED; // see RULE_08
          end else begin
            st_d      = OTFR_OFF_WAIT;
            tmr_start = 1'b1;
          end
        end
      end
      OTFR_OFF_WAIT: begin
        if (tmr_exp) begin
          // Attempt: re-enable and count it unless retries are endless
          st_d      = OTFR_TRY; // see RULE_09
          oen_d     = 1'b1;
          rst_stb_d = 1'b1;
          if (retry_lim != `OTFR_RETRY_INF) begin
            used_d = used_q + 3'h1; // see RULE_07
          end
        end
      end
      OTFR_TRY: begin
        if (!ot_fault) begin
          st_d = OTFR_RUN;
        end else begin
          oen_d = 1'b0;
          if (retry_lim == `OTFR_RETRY_INF || used_q < retry_lim) begin
            st_d      = OTFR_OFF_WAIT; // see RULE_07
            tmr_start = 1'b1;
          end else begin
            st_d = OTFR_LATCHED; // see RULE_08
          end
        end
      end
      OTFR_WAIT_CLEAR: begin
        oen_d = 1'b0;
        if (!ot_fault) begin
          st_d  = OTFR_RUN; // see RULE_06
          oen_d = 1'b1;
        end
      end
      OTFR_LATCHED: begin
        oen_d = 1'b0; // see RULE_08
      end
      default: begin
        st_d  = OTFR_LATCHED;
        oen_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= OTFR_RUN;
      used_q    <= 3'h0;
      oen_q     <= 1'b1;
      rst_stb_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      used_q    <= used_d;
      oen_q     <= oen_d;
      rst_stb_q <= rst_stb_d;
    end
  end

  logic latched_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latched_q <= 1'b0;
    end else begin
      latched_q <= (st_d == OTFR_LATCHED);
    end
  end

  otfr_ms_timer #(
    .CYC_PER_MS (CYC_PER_MS)
  ) u_timer (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .start   (tmr_start),
    .load_ms (tmr_ms),
    .expired (tmr_exp)
  );

  assign reg_rdata     = rdata_q;
  assign out_enable    = oen_q;
  assign restart_stb   = rst_stb_q;
  assign fault_latched = latched_q;

endmodule // otfr_fault_resp

`default_nettype wire

// >>> verif/otfr_fault_resp_properties.sv
// Port checker for otfr_fault_resp.
// Assumes it is bound to that module and CYC_PER_MS is 2 or more.
`default_nettype none
module otfr_fault_resp_properties #(
  parameter int CYC_PER_MS = 125000
) (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Register port
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Fault and power stage
  input wire logic       ot_fault,
  input wire logic       out_enable,
  input wire logic       restart_stb,
  input wire logic       fault_latched
);
  logic [7:0] cfg_q;
  logic [1:0] rsp;

  // Shadow of the action register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) cfg_q <= 8'h00;
    else if (reg_wr_en && reg_addr == 8'h50) cfg_q <= reg_wdata;
  end
  assign rsp = cfg_q[7:6];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_on8; out_enable [*8]; endsequence
  sequence s_off8; !out_enable [*8]; endsequence

  a_ignore_fault: assert property (
    rsp == 2'h0 && $past(rsp) == 2'h0 && out_enable |=> out_enable)
    else $error("output dropped with faults ignored");
  a_hold_ride: assert property (
    rsp == 2'h1 && $rose(ot_fault) && out_enable |=> s_on8)
    else $error("output dropped during hold");
  a_shut_fast: assert property (
    rsp == 2'h2 && ot_fault && out_enable |=> !out_enable)
    else $error("no shutdown on fault");
  a_wait_off: assert property (
    rsp == 2'h3 && ot_fault |=> !out_enable)
    else $error("output on while fault present");
  a_wait_back: assert property (
    rsp == 2'h3 && !ot_fault && !out_enable |=> out_enable)
    else $error("output not restored after clear");
  a_latch_hold: assert property (
    fault_latched |=> fault_latched && !out_enable)
    else $error("latched state left");
  a_retry_gap: assert property (
    $fell(out_enable) && rsp == 2'h2 |=> s_off8)
    else $error("restart too soon");
  a_stb_single: assert property (
    restart_stb |-> out_enable ##1 !restart_stb)
    else $error("bad restart pulse");
  a_rdata_map: assert property (
    reg_addr == 8'h50 |=> reg_rdata == $past(cfg_q))
    else $error("register read mismatch");
  a_rdata_zero: assert property (
    reg_addr != 8'h50 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule // otfr_fault_resp_properties

bind otfr_fault_resp otfr_fault_resp_properties #(
  .CYC_PER_MS(CYC_PER_MS)
) u_props (
  .mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ot_fault(ot_fault), .out_enable(out_enable),
  .restart_stb(restart_stb), .fault_latched(fault_latched)
);
`default_nettype wire

// >>> verif/otfr_fault_resp_tb_top.sv
// Bench for otfr_fault_resp: response-code table, then edge cases.
// Assumes the block and its checker are compiled before this file.
`default_nettype none
module otfr_fault_resp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       reg_wr_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       ot_fault = 1'b0;
  logic [7:0] reg_rdata;
  logic       out_enable;
  logic       restart_stb;
  logic       fault_latched;
  int         n_fail = 0;
  int         n_checks = 0;
  int         n;
  // Config, output under fault, output after clear
  logic [9:0] rows [4] = '{10'h003, 10'h123, 10'h220, 10'h301};

  always #4 mclk = ~mclk;

  otfr_fault_resp #(.CYC_PER_MS(2)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ot_fault(ot_fault), .out_enable(out_enable),
    .restart_stb(restart_stb), .fault_latched(fault_latched)
  );

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst();
    @(negedge mclk);
    rst_n = 1'b0;
    ot_fault = 1'b0;
    repeat (2) @(negedge mclk);
    rst_n = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge mclk);
    reg_wr_en = 1'b0;
  endtask

  // Counts cycles until the chosen output reaches v
  task automatic wait_for(input int s, input logic v);
    n = 0;
    while ((s == 0 ? out_enable : s == 1 ? restart_stb : fault_latched)
           !== v) begin
      @(negedge mclk);
      n++;
      if (n > 3000) begin
        n_fail++;
        end_of_test();
      end
    end
  endtask

  initial begin
    rst();
    reg_addr = 8'h50;
    @(negedge mclk);
    chk(reg_rdata, 8'h00);
    wr(8'h50, 8'hA5);
    @(negedge mclk);
    chk(reg_rdata, 8'hA5);
    wr(8'h33, 8'h5A);
    @(negedge mclk);
    chk(reg_rdata, 8'h00);
    foreach (rows[i]) begin
      rst();
      wr(8'h50, rows[i][9:2]);
      ot_fault = 1'b1;
      repeat (3) @(negedge mclk);
      chk(out_enable, rows[i][1]);
      ot_fault = 1'b0;
      repeat (3) @(negedge mclk);
      chk(out_enable, rows[i][0]);
    end
    // Hold time doubles with each delay code, no retries
    for (int c = 0; c < 8; c++) begin
      rst();
      wr(8'h50, 8'h40 | 8'(c));
      ot_fault = 1'b1;
      wait_for(0, 1'b0);
      chk(n >= (20 << c) && n <= (20 << c) + 4, 8'h01);
    end
    // Ride through 20 cycles, one attempt 504 cycles on, then latch
    rst();
    wr(8'h50, 8'h48);
    ot_fault = 1'b1;
    wait_for(0, 1'b0);
    chk(n >= 20 && n <= 24, 8'h01);
    wait_for(1, 1'b1);
    chk(n >= 500 && n <= 508, 8'h01);
    wait_for(2, 1'b1);
    chk(n <= 3, 8'h01);
    ot_fault = 1'b0;
    repeat (10) @(negedge mclk);
    chk({fault_latched, out_enable}, 8'h02);
    rst();
    chk({fault_latched, out_enable}, 8'h01);
    // Two attempts 1116 cycles apart, then latch
    wr(8'h50, 8'h91);
    ot_fault = 1'b1;
    for (int k = 0; k < 2; k++) begin
      wait_for(1, 1'b1);
      chk(n >= 1110 && n <= 1122, 8'h01);
      wait_for(1, 1'b0);
    end
    wait_for(2, 1'b1);
    chk(n <= 3, 8'h01);
    // No attempts allowed: latch at once
    rst();
    wr(8'h50, 8'h80);
    ot_fault = 1'b1;
    repeat (3) @(negedge mclk);
    chk({fault_latched, restart_stb}, 8'h02);
    // Endless retries never latch
    rst();
    wr(8'h50, 8'hB8);
    ot_fault = 1'b1;
    for (int k = 0; k < 3; k++) begin
      wait_for(1, 1'b1);
      wait_for(1, 1'b0);
    end
    chk(fault_latched, 8'h00);
    end_of_test();
  end
endmodule // otfr_fault_resp_tb_top
`default_nettype wire
